// >>> mg_consts.svh
`ifndef MG_CONSTS_SVH
`define MG_CONSTS_SVH
// Fixed memory partition (byte addresses, 16-bit space)
`define MG_ROM_BASE 16'h0000
`define MG_ROM_FW_END 16'h0fff
`define MG_ROM_END 16'h7fff
`define MG_EE_BASE 16'h8000
`define MG_EE_FW_BASE 16'h8000
`define MG_EE_FW_END 16'h82ff
`define MG_EE_END 16'hbfff
`define MG_RAM_BASE 16'hc000
`define MG_RAM_FW_END 16'hc1ff
`define MG_RAM_END 16'hefff
`define MG_SFR_BASE 16'hf000
// Segmentation configuration registers (SFR byte offsets) and segment count
`define MG_SFR_TBL_LO 8'h00
`define MG_SFR_TBL_HI 8'h01
`define MG_SFR_XBASE 8'h02
`define MG_SFR_XSIZE 8'h03
`define MG_SFR_FWCTRL 8'h04
`define MG_SFR_SEGCNT 8
// Restrictive reset defaults
`define MG_TBL_RESET 16'h0000
`define MG_X_RESET 8'h00
`define MG_FWCTRL_RESET 8'h00
// Segment entry: [15:8] page base, [7:4] page count, bit2 r, bit1 w, bit0 x
`define MG_ENT_R 2
`define MG_ENT_W 1
`define MG_ENT_X 0
`define MG_ENT_VALID 3
`endif

// >>> mg_cpu_model.sv
`timescale 1ns/100ps
// CPU core model: one mode-tagged request per call, back to back if called each cycle
module mg_cpu_model (
	input wire logic ref_clk,
	output logic req_valid,
	output mg_pkg::mg_req_t req
);
	import mg_pkg::*;
	// Quiet bus at time zero
	initial begin
		req_valid = 1'b0;
		req = '0;
	end
	// Request launched just after an edge and held until the next one
	task automatic issue(input logic [15:0] a, input logic [7:0] d, input mg_op_t o, input mg_mode_t m,
		input logic i);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req <= {a, d, o, m, i};
	endtask
	// Inverted fields when idle, so a stale request is never mistaken for a live one
	task automatic idle();
		@(posedge ref_clk);
		req_valid <= 1'b0;
		req <= ~req;
	endtask
endmodule

// >>> mg_guard.sv
`timescale 1ns/100ps
`include "mg_consts.svh"
// Behaviour
// (R01) Reset clears the segment-table location, disabling all segments until System Mode sets it.
// (R02) Segmentation configuration registers accept writes only from System Mode.
// (R03) System Mode may move the table base and rewrite entries in writable memory.
// (R04) User Mode writes to the table pointer have no effect.
// (R05) User Mode may write table entries only inside a segment it may write.
// (R06) Firmware integrity reaches all EEPROM on writes; other firmware confined to firmware EEPROM.
// (R07) Firmware kept apart by partition; RAM exchange window set by System Mode.
// (R08) Memory partition is fixed in hardware, no register changes it.
// (R09) Security registers change only from a mode allowed to write them.
// (R10) No means exists to substitute other reset defaults for security attributes.
// (R11) User Mode rights come from the segment entry covering the address.
// (R12) Violating accesses are suppressed and raise a violation pulse to the CPU.
module mg_guard (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire mg_pkg::mg_req_t req,
	input wire logic test_pin,
	output logic grant_valid,
	output logic [15:0] grant_addr,
	output logic [7:0] grant_wdata,
	output logic grant_write,
	output logic violation,
	output logic [15:0] tbl_base
);
	import mg_pkg::*;
	typedef struct packed {
		logic [15:0] tbl;
		logic [7:0] xbase;
		logic [7:0] xsize;
		logic [7:0] fwctrl;
		logic gv;
		logic [15:0] ga;
		logic [7:0] gd;
		logic gw;
		logic viol;
		logic [2:0] scan;
		logic [`MG_SFR_SEGCNT-1:0][15:0] ent;
	} mg_guard_st_t;
	mg_guard_st_t st;
	mg_guard_st_t next_st;
	mg_seg_if seg ();
	logic test_lvl;
	logic is_sfr;
	logic is_rom;
	logic is_ee;
	logic is_ram;
	logic in_fw_rom;
	logic in_fw_ee;
	logic in_fw_ram;
	logic in_xch;
	logic in_tbl;
	logic [7:0] sfr_off;
	logic [2:0] urights;
	logic user_ok;
	logic allow;
	logic seg_sfr;
	logic [15:0] xch_lo;
	logic [16:0] xch_hi;
	// Table entry shadow: written by the guard alongside memory writes into the table
	mg_seg_mem u_mem (
		.ref_clk(ref_clk),
		.reset(reset),
		.seg(seg)
	);
	// Test strap pin kept off the access path; only qualifies the test mode
	mg_pin_sync u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.pin(test_pin),
		.level(test_lvl)
	);
	// Fixed decode; these are constants so no software can reshape the partition
	always_comb begin
		is_rom = req.addr <= `MG_ROM_END; // R08
		is_ee = req.addr >= `MG_EE_BASE && req.addr <= `MG_EE_END;
		is_ram = req.addr >= `MG_RAM_BASE && req.addr <= `MG_RAM_END;
		is_sfr = req.addr >= `MG_SFR_BASE;
		in_fw_rom = req.addr <= `MG_ROM_FW_END;
		in_fw_ee = req.addr >= `MG_EE_FW_BASE && req.addr <= `MG_EE_FW_END;
		in_fw_ram = req.addr >= `MG_RAM_BASE && req.addr <= `MG_RAM_FW_END;
		sfr_off = req.addr[7:0];
		seg_sfr = is_sfr && sfr_off <= `MG_SFR_FWCTRL;
		xch_lo = `MG_RAM_BASE + {4'h0, st.xbase, 4'h0};
		xch_hi = {1'b0, xch_lo} + {9'h000, st.xsize};
		in_xch = st.xsize != `MG_X_RESET && req.addr >= xch_lo && {1'b0, req.addr} < xch_hi;
		in_tbl = req.addr[15:4] == st.tbl[15:4] && st.tbl != `MG_TBL_RESET;
	end
	// User rights: OR over segments whose range covers the address
	// Match is made from the cached entries against the live address,
	// so rights found for one access never carry over to the next one
	genvar gi;
	logic [`MG_SFR_SEGCNT-1:0] seg_hit;
	logic [`MG_SFR_SEGCNT-1:0][2:0] seg_r;
	generate
		for (gi = 0; gi < `MG_SFR_SEGCNT; gi++) begin : g_seg
			// Valid entry, page at or above its base and below base plus count
			assign seg_hit[gi] = st.ent[gi][`MG_ENT_VALID] && req.addr[15:8] >= st.ent[gi][15:8] &&
				{1'b0, req.addr[15:8]} < {1'b0, st.ent[gi][15:8]} + {5'h00, st.ent[gi][7:4]};
			assign seg_r[gi] = seg_hit[gi] ? st.ent[gi][2:0] : 3'h0; // R11
		end
	endgenerate
	always_comb begin
		urights = 3'h0;
		for (int i = 0; i < `MG_SFR_SEGCNT; i++) begin
			urights = urights | seg_r[i];
		end
	end
	// Per-mode access decision
	always_comb begin
		user_ok = 1'b0;
		case (req.op)
			MG_OP_READ: user_ok = urights[`MG_ENT_R];
			MG_OP_WRITE: user_ok = urights[`MG_ENT_W];
			MG_OP_FETCH: user_ok = urights[`MG_ENT_X];
			default: user_ok = 1'b0;
		endcase
		allow = 1'b0;
		case (req.mode)
			MG_BOOT: allow = !seg_sfr && (is_rom ? req.op != MG_OP_WRITE : 1'b1);
			MG_TEST: allow = test_lvl && !seg_sfr && (is_rom ? req.op != MG_OP_WRITE : 1'b1); // R02
			MG_FW: begin
				if (seg_sfr) begin
					allow = req.op == MG_OP_READ && sfr_off == `MG_SFR_FWCTRL; // R09
				end else if (is_sfr) begin
					allow = st.fwctrl[0] || req.op == MG_OP_READ;
				end else if (is_rom) begin
					allow = in_fw_rom && req.op != MG_OP_WRITE; // R07
				end else if (is_ee) begin
					allow = (req.integ && req.op != MG_OP_FETCH) || in_fw_ee; // R06
				end else begin
					allow = req.op != MG_OP_FETCH && (in_fw_ram || in_xch); // R07
				end
			end
			MG_SYS: begin
				if (is_rom) begin
					allow = !in_fw_rom && req.op != MG_OP_WRITE;
				end else if (is_ee) begin
					allow = !in_fw_ee; // R07
				end else if (is_ram) begin
					allow = !in_fw_ram && req.op != MG_OP_FETCH;
				end else begin
					allow = req.op != MG_OP_FETCH; // R02
				end
			end
			MG_USER: begin
				if (seg_sfr) begin
					allow = 1'b0; // R04
				end else if (is_sfr) begin
					allow = user_ok && req.op != MG_OP_FETCH;
				end else if (in_fw_rom || in_fw_ee || in_fw_ram) begin
					allow = 1'b0;
				end else begin
					// ROM stays read-only even where a segment grants write
					allow = user_ok && !(is_rom && req.op == MG_OP_WRITE); // R11 R05
				end
			end
			default: allow = 1'b0;
		endcase
	end
	// Register updates and the granted access
	always_comb begin
		next_st = st;
		next_st.gv = 1'b0;
		next_st.gw = 1'b0;
		next_st.viol = 1'b0;
		seg.wr = 1'b0;
		seg.widx = req.addr[3:1];
		seg.wdata = {req.wdata, req.wdata};
		seg.ridx = st.scan;
		// Refresh one cached entry per cycle from the table store
		next_st.scan = st.scan + 3'h1;
		// Store data lag the read index by one cycle, so they belong to the previous slot
		next_st.ent[st.scan - 3'h1] = seg.rdata;
		if (req_valid) begin
			if (allow) begin
				next_st.gv = 1'b1; // R12
				next_st.ga = req.addr;
				next_st.gd = req.wdata;
				next_st.gw = req.op == MG_OP_WRITE;
				if (req.op == MG_OP_WRITE && seg_sfr && req.mode == MG_SYS) begin
					case (sfr_off)
						`MG_SFR_TBL_LO: next_st.tbl[7:0] = req.wdata; // R03
						`MG_SFR_TBL_HI: next_st.tbl[15:8] = req.wdata; // R03
						`MG_SFR_XBASE: next_st.xbase = req.wdata; // R07
						`MG_SFR_XSIZE: next_st.xsize = req.wdata;
						`MG_SFR_FWCTRL: next_st.fwctrl = req.wdata; // R09
						default: next_st.tbl = st.tbl;
					endcase
				end
				// Table writes land in the lookup store only when the target was writable
				if (req.op == MG_OP_WRITE && in_tbl && !is_rom) begin
					seg.wr = 1'b1; // R05
				end
			end else begin
				next_st.viol = 1'b1; // R12
			end
		end
	end
	// Restrictive constants only; there is no load path for alternative defaults
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st <= '0;
			st.tbl <= `MG_TBL_RESET; // R01 R10
			st.xbase <= `MG_X_RESET;
			st.xsize <= `MG_X_RESET;
			st.fwctrl <= `MG_FWCTRL_RESET;
		end else begin
			st <= next_st;
		end
	end
	assign grant_valid = st.gv;
	assign grant_addr = st.ga;
	assign grant_wdata = st.gd;
	assign grant_write = st.gw;
	assign violation = st.viol;
	assign tbl_base = st.tbl;
	// Checks
	sequence s_user_ptr_write;
		req_valid && req.mode == MG_USER && req.op == MG_OP_WRITE && seg_sfr;
	endsequence
	// Every taken request is answered one cycle later, by exactly one of the two pulses
	sequence s_granted;
		##1 (grant_valid && !violation);
	endsequence
	sequence s_refused;
		##1 (violation && !grant_valid);
	endsequence
	chk_reset_tbl_zero: assert property (@(posedge ref_clk) $fell(reset) |-> tbl_base == 16'h0000) // R01
		else $error("table base not zero after reset");
	chk_user_ptr_block: assert property (@(posedge ref_clk) disable iff (reset)
		s_user_ptr_write |=> $stable(tbl_base) && violation && !grant_valid) // R04
		else $error("user changed table pointer");
	chk_nonsys_cfg: assert property (@(posedge ref_clk) disable iff (reset)
		req_valid && req.mode != MG_SYS && seg_sfr |=> $stable(tbl_base)) // R02
		else $error("non-system mode changed configuration");
	chk_sys_relocate: assert property (@(posedge ref_clk) disable iff (reset)
		req_valid && req.mode == MG_SYS && req.op == MG_OP_WRITE && is_sfr && sfr_off == 8'h01
		|=> tbl_base[15:8] == $past(req.wdata)) // R03
		else $error("system relocation lost");
	chk_viol_excl: assert property (@(posedge ref_clk) disable iff (reset) !(violation && grant_valid)) // R12
		else $error("violation and grant together");
	chk_viol_cause: assert property (@(posedge ref_clk) disable iff (reset) // R12
		req_valid && !allow |-> s_refused)
		else $error("violation not raised");
	chk_fw_ee_fence: assert property (@(posedge ref_clk) disable iff (reset)
		req_valid && req.mode == MG_FW && !req.integ && is_ee && !in_fw_ee |=> violation) // R06
		else $error("firmware left its eeprom area");
	chk_user_rights: assert property (@(posedge ref_clk) disable iff (reset)
		req_valid && req.mode == MG_USER && !seg_sfr && !user_ok |=> !grant_valid) // R11
		else $error("user access without segment rights");
	chk_fw_sfr_ro: assert property (@(posedge ref_clk) disable iff (reset)
		req_valid && req.mode == MG_FW && req.op == MG_OP_WRITE && seg_sfr |=> violation) // R09
		else $error("firmware wrote firewall setting");
	chk_answer_once: assert property (@(posedge ref_clk) disable iff (reset) // R12
		req_valid |=> grant_valid || violation)
		else $error("request left without answer");
	chk_quiet_bus: assert property (@(posedge ref_clk) disable iff (reset) // R12
		!req_valid |=> !grant_valid && !violation)
		else $error("answer without request");
	chk_nonsys_refused: assert property (@(posedge ref_clk) disable iff (reset) // R02
		req_valid && req.mode != MG_SYS && seg_sfr && req.op == MG_OP_WRITE |-> s_refused)
		else $error("configuration write from other mode not refused");
	chk_sys_tbl_lo: assert property (@(posedge ref_clk) disable iff (reset) // R03
		req_valid && req.mode == MG_SYS && req.op == MG_OP_WRITE && seg_sfr && sfr_off == 8'h00
		|=> tbl_base[7:0] == $past(req.wdata))
		else $error("system table base low byte lost");
	chk_cfg_quiet: assert property (@(posedge ref_clk) disable iff (reset) // R09
		!req_valid |=> $stable(tbl_base))
		else $error("table base moved without request");
	// The strap only qualifies the mode; it never opens access by itself
	chk_test_strap: assert property (@(posedge ref_clk) disable iff (reset) // R12
		req_valid && req.mode == MG_TEST && !test_lvl |-> s_refused)
		else $error("test access without strap");
	chk_fw_rom_fence: assert property (@(posedge ref_clk) disable iff (reset) // R07
		req_valid && req.mode == MG_FW && is_rom && !in_fw_rom |-> s_refused)
		else $error("firmware reached application rom");
	chk_sys_fw_fence: assert property (@(posedge ref_clk) disable iff (reset) // R07
		req_valid && req.mode == MG_SYS && (in_fw_rom || in_fw_ee || in_fw_ram) |-> s_refused)
		else $error("system reached firmware area");
	chk_user_fw_fence: assert property (@(posedge ref_clk) disable iff (reset) // R07
		req_valid && req.mode == MG_USER && (in_fw_rom || in_fw_ee || in_fw_ram) |-> s_refused)
		else $error("user reached firmware area");
	chk_integ_reach: assert property (@(posedge ref_clk) disable iff (reset) // R06
		req_valid && req.mode == MG_FW && req.integ && is_ee && req.op == MG_OP_WRITE |-> s_granted)
		else $error("integrity write refused");
	chk_fw_ram_fixed: assert property (@(posedge ref_clk) disable iff (reset) // R08
		req_valid && req.mode == MG_FW && in_fw_ram && req.op != MG_OP_FETCH |-> s_granted)
		else $error("firmware ram partition not fixed");
	chk_xch_fence: assert property (@(posedge ref_clk) disable iff (reset) // R07
		req_valid && req.mode == MG_FW && is_ram && !in_fw_ram && !in_xch |-> s_refused)
		else $error("firmware left exchange window");
	// Table store only changes behind a granted write
	chk_tbl_write_gate: assert property (@(posedge ref_clk) disable iff (reset) // R05
		seg.wr |-> req_valid && allow && req.op == MG_OP_WRITE)
		else $error("table store written without grant");
	chk_user_tbl_block: assert property (@(posedge ref_clk) disable iff (reset) // R05
		req_valid && req.mode == MG_USER && in_tbl && !urights[`MG_ENT_W] |-> !seg.wr)
		else $error("user wrote table without write right");
	chk_grant_echo: assert property (@(posedge ref_clk) disable iff (reset) // R12
		req_valid && allow |=> grant_addr == $past(req.addr) && grant_write == ($past(req.op) == MG_OP_WRITE))
		else $error("granted access altered");
endmodule

// >>> mg_guard_tb.sv
`timescale 1ns/100ps
module mg_guard_tb;
	import mg_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic test_pin = 1'b1;
	logic req_valid;
	mg_req_t req;
	logic grant_valid, grant_write, violation;
	logic [15:0] grant_addr, tbl_base;
	logic [7:0] grant_wdata;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int k;
	logic [25:0] notes[$];
	logic [25:0] n;
	logic [31:0] seed = 32'h00464716;
	// 10 MHz clock
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	mg_cpu_model mg_cpu_model_i (.ref_clk(ref_clk), .req_valid(req_valid), .req(req));
	mg_guard mg_guard_i (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req(req),
		.test_pin(test_pin), .grant_valid(grant_valid), .grant_addr(grant_addr),
		.grant_wdata(grant_wdata), .grant_write(grant_write), .violation(violation),
		.tbl_base(tbl_base));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		check("pending answers", notes.size(), 0);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Issue one access and note whether it should pass: {grant, write, addr, wdata}
	task automatic acc(input logic [15:0] a, input logic [7:0] d, input mg_op_t o, input mg_mode_t m,
		input logic i, input logic g);
		mg_cpu_model_i.issue(a, d, o, m, i);
		notes.push_back({g, o == MG_OP_WRITE, a, d});
	endtask
	// Answers sampled mid-cycle, where registered outputs have settled
	always @(negedge ref_clk) begin
		if (grant_valid === 1'b1 || violation === 1'b1) begin
			if (notes.size() == 0) begin
				check("unrequested answer", 1, 0);
			end else begin
				n = notes.pop_front();
				check("grant", grant_valid, n[25]);
				check("violation", violation, !n[25]);
				if (n[25]) begin
					check("grant_addr", grant_addr, n[23:8]);
					check("grant_write", grant_write, n[24]);
					if (n[24]) check("grant_wdata", grant_wdata, n[7:0]);
				end
			end
		end
	end
	// Hang guard: the whole sequence needs well under this many cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		check("tbl_base after reset", tbl_base, 16'h0000);
		// Empty table: every user access below the SFR space is refused
		for (k = 0; k < 8; k++) begin
			acc($random(seed) % 32'hf000, $random(seed), mg_op_t'(k % 3), MG_USER, 1'b0, 1'b0);
		end
		acc(16'hf000, 8'h00, MG_OP_WRITE, MG_SYS, 1'b0, 1'b1);
		acc(16'hf001, 8'hd0, MG_OP_WRITE, MG_SYS, 1'b0, 1'b1);
		acc(16'hf001, 8'h55, MG_OP_WRITE, MG_USER, 1'b0, 1'b0);
		acc(16'hf001, 8'h66, MG_OP_WRITE, MG_BOOT, 1'b0, 1'b0);
		acc(16'hf000, 8'h77, MG_OP_WRITE, MG_FW, 1'b0, 1'b0);
		acc(16'hf000, 8'h88, MG_OP_WRITE, MG_TEST, 1'b0, 1'b0);
		acc(16'hd000, 8'h12, MG_OP_WRITE, MG_USER, 1'b0, 1'b0);
		acc(16'hd000, 8'h34, MG_OP_WRITE, MG_SYS, 1'b0, 1'b1);
		// Exchange window c200..c20f, then firmware partition and firewall
		acc(16'hf002, 8'h20, MG_OP_WRITE, MG_SYS, 1'b0, 1'b1);
		acc(16'hf003, 8'h10, MG_OP_WRITE, MG_SYS, 1'b0, 1'b1);
		mg_cpu_model_i.idle();
		mg_cpu_model_i.idle();
		check("tbl_base moved", tbl_base, 16'hd000);
		acc(16'hc205, 8'h00, MG_OP_READ, MG_FW, 1'b0, 1'b1);
		acc(16'hc215, 8'h00, MG_OP_READ, MG_FW, 1'b0, 1'b0);
		acc(16'hd000, 8'h00, MG_OP_READ, MG_FW, 1'b0, 1'b0);
		acc(16'h9000, 8'ha5, MG_OP_WRITE, MG_FW, 1'b1, 1'b1);
		acc(16'h9000, 8'h5a, MG_OP_WRITE, MG_FW, 1'b0, 1'b0);
		acc(16'h8100, 8'h3c, MG_OP_WRITE, MG_FW, 1'b0, 1'b1);
		acc(16'hf004, 8'h01, MG_OP_WRITE, MG_FW, 1'b0, 1'b0);
		acc(16'hf004, 8'h00, MG_OP_READ, MG_FW, 1'b0, 1'b1);
		acc(16'h9000, 8'hc3, MG_OP_WRITE, MG_TEST, 1'b0, 1'b1);
		acc(16'h2000, 8'h00, MG_OP_READ, MG_FW, 1'b0, 1'b0);
		acc(16'h8100, 8'h00, MG_OP_READ, MG_SYS, 1'b0, 1'b0);
		acc(16'hc100, 8'h00, MG_OP_READ, MG_FW, 1'b0, 1'b1);
		// Entry 1: pages cf..da, valid, all rights; the guard's cached entries need a full scan to pick it up
		acc(16'hd002, 8'hcf, MG_OP_WRITE, MG_SYS, 1'b0, 1'b1);
		repeat (12) mg_cpu_model_i.idle();
		acc(16'hd004, 8'h9f, MG_OP_WRITE, MG_USER, 1'b0, 1'b1);
		acc(16'hd010, 8'h00, MG_OP_READ, MG_USER, 1'b0, 1'b1);
		acc(16'hc100, 8'h00, MG_OP_READ, MG_USER, 1'b0, 1'b0);
		acc(16'hf001, 8'h11, MG_OP_WRITE, MG_USER, 1'b0, 1'b0);
		repeat (12) mg_cpu_model_i.idle();
		// Entry 2 written by user code: pages 9f..a7 in application eeprom
		acc(16'ha000, 8'h00, MG_OP_READ, MG_USER, 1'b0, 1'b1);
		// Strap low: test mode is refused once the synchroniser has settled
		test_pin <= 1'b0;
		repeat (4) mg_cpu_model_i.idle();
		acc(16'h9000, 8'h00, MG_OP_READ, MG_TEST, 1'b0, 1'b0);
		mg_cpu_model_i.idle();
		repeat (3) @(posedge ref_clk);
		// Second reset in mid-run restores the restrictive defaults
		reset <= 1'b1;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		check("tbl_base after second reset", tbl_base, 16'h0000);
		acc(16'h1000, 8'h00, MG_OP_FETCH, MG_USER, 1'b0, 1'b0);
		acc(16'ha000, 8'h00, MG_OP_READ, MG_USER, 1'b0, 1'b0);
		mg_cpu_model_i.idle();
		repeat (3) @(posedge ref_clk);
		conclude();
	end
endmodule

// >>> mg_pin_sync.sv
`timescale 1ns/100ps
// Three-stage synchroniser; change accepted once stages two and three agree
module mg_pin_sync (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic pin,
	output logic level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} mg_sync_st_t;
	mg_sync_st_t st;
	mg_sync_st_t next_st;
	always_comb begin
		next_st = st;
		next_st.s1 = pin;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.s2 == st.s3) begin
			next_st.lvl = st.s3;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign level = st.lvl;
endmodule

// >>> mg_pkg.sv
package mg_pkg;
	typedef enum logic [4:0] {
		MG_BOOT = 5'h01,
		MG_TEST = 5'h02,
		MG_FW = 5'h04,
		MG_SYS = 5'h08,
		MG_USER = 5'h10
	} mg_mode_t;
	typedef enum logic [1:0] {
		MG_OP_READ = 2'h0,
		MG_OP_WRITE = 2'h1,
		MG_OP_FETCH = 2'h2
	} mg_op_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		mg_op_t op;
		mg_mode_t mode;
		logic integ;
	} mg_req_t;
endpackage

// >>> mg_seg_if.sv
`timescale 1ns/100ps
// Carries the segment lookup between the guard and its table memory
interface mg_seg_if;
	logic wr;
	logic [2:0] widx;
	logic [15:0] wdata;
	logic [2:0] ridx;
	logic [15:0] rdata;
	modport guard (output wr, output widx, output wdata, output ridx, input rdata);
	modport table_side (input wr, input widx, input wdata, input ridx, output rdata);
endinterface

// >>> mg_seg_mem.sv
`timescale 1ns/100ps
`include "mg_consts.svh"
// Cached segment entries; read data come out of a register
module mg_seg_mem (
	input wire logic ref_clk,
	input wire logic reset,
	mg_seg_if.table_side seg
);
	import mg_pkg::*;
	typedef struct packed {
		logic [`MG_SFR_SEGCNT-1:0][15:0] ent;
		logic [15:0] rdata;
	} mg_mem_st_t;
	mg_mem_st_t st;
	mg_mem_st_t next_st;
	// Entries clear to zero so every segment starts disabled
	always_comb begin
		next_st = st;
		next_st.rdata = st.ent[seg.ridx];
		if (seg.wr) begin
			next_st.ent[seg.widx] = seg.wdata;
			if (seg.widx == seg.ridx) begin
				next_st.rdata = seg.wdata;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st <= '0; // R01
		end else begin
			st <= next_st;
		end
	end
	assign seg.rdata = st.rdata;
endmodule
